//--- hw/pvr_regs.sv
// Vendor management register bank with extended-space portal.
// Assumes management frames are decoded upstream into one-cycle strobes.
// Summary of operation
// RULE1 - Latency bit selects variable or fixed latency
// RULE2 - Every 100M preamble byte reaches interface
// RULE3 - 10M preamble stripped unless restore bit set
// RULE4 - Eight interrupt enables in upper byte, reset zero
// RULE5 - Eight event flags, read-only, cleared on read
// RULE6 - Interrupt asserts on enabled set flag
// RULE7 - Polarity bit sets interrupt pin level
// RULE8 - Diagnostic enable bit self-clears on completion
// RULE9 - Cable result code and short-cable flag
// RULE10 - Link, polarity, crossover, energy status bits
// RULE11 - Isolate bit places PHY in isolate
// RULE12 - Three-bit operating mode report
// RULE13 - Swap disable plus select fixes pair roles
// RULE14 - Crossover algorithm select, default standard
// RULE15 - Force link bypasses link control
// RULE16 - Jabber counter enable, power saving enable
// RULE17 - Reference clock select for crystal input
// RULE18 - Two-bit indicator mode field
// RULE19 - Transmit, loopback, SQE, scrambler controls
// RULE20 - Portal reaches 32 devices of 64K registers
// RULE21 - Operation field selects data portal behaviour
// RULE22 - Op zero accesses address, else data
// RULE23 - Manager sets address then data operation
module pvr_regs
  import pvr_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire pvr_req_t req,
  input wire pvr_stat_t stat,
  output logic [15:0] rdata,
  output pvr_ctrl_t ctrl,
  output logic irq_pin,
  output logic ext_wr,
  output logic ext_rd,
  output logic [4:0] ext_dev,
  output logic [15:0] ext_addr,
  output logic [15:0] ext_wdata,
  input wire logic [15:0] ext_rdata,
  output logic transmit_pair_is_rx,
  output logic first_indicator_output,
  output logic second_indicator_output,
  input wire logic speed_100,
  input wire logic activity
);

  // Register state and next values
  logic [15:0] ectl_q, ectl_d;
  logic [15:0] eaddr_q, eaddr_d;
  logic [15:0] eaddr_hold_q, eaddr_hold_d;
  logic [4:0] edev_q, edev_d;
  logic [15:0] exp_q, exp_d;
  logic [7:0] ien_q, ien_d;
  logic [7:0] iflag_q, iflag_d;
  logic irq_q, irq_d;
  logic [15:0] cab_q, cab_d;
  logic [15:0] phy1_q, phy1_d;
  logic [15:0] phy2_q, phy2_d;
  logic [15:0] rdata_d;
  logic ewr_q, ewr_d;
  logic erd_q, erd_d;
  logic [15:0] ewdata_q, ewdata_d;
  logic pair_q, pair_d;
  logic first_indicator_output_q, first_indicator_output_d;
  logic second_indicator_output_q, second_indicator_output_d;
  // Decoded portal mode and per-register strobes
  pvr_op_t op;
  logic data_mode;
  logic post_inc;
  logic wr_ctrl;
  logic wr_data;
  logic wr_exp;
  logic wr_int;
  logic wr_cab;
  logic wr_phy1;
  logic wr_phy2;
  logic rd_data;
  logic rd_int;

  // Operation field and write or read hits, by address
  assign op = pvr_op_t'(ectl_q[15:14]);
  assign data_mode = (op != PVR_OP_ADDR);
  assign wr_ctrl = req.wr && (req.addr == PVR_ADDR_EXT_CTRL);
  assign wr_data = req.wr && (req.addr == PVR_ADDR_EXT_DATA);
  assign wr_exp = req.wr && (req.addr == PVR_ADDR_EXP_RX);
  assign wr_int = req.wr && (req.addr == PVR_ADDR_INT);
  assign wr_cab = req.wr && (req.addr == PVR_ADDR_CABLE);
  assign wr_phy1 = req.wr && (req.addr == PVR_ADDR_PHY1);
  assign wr_phy2 = req.wr && (req.addr == PVR_ADDR_PHY2);
  assign rd_data = req.rd && (req.addr == PVR_ADDR_EXT_DATA);
  assign rd_int = req.rd && (req.addr == PVR_ADDR_INT);

  // Portal: control word, register address and post-increment
  always_comb begin
    ectl_d = ectl_q;
    eaddr_d = eaddr_q;
    post_inc = 1'b0;
    if (wr_ctrl) begin
      ectl_d = req.wdata; // see RULE20
    end
    if (wr_data && !data_mode) begin
      eaddr_d = req.wdata; // see RULE22
    end
    // Writes step in both increment modes, reads in one only
    if (wr_data && (op == PVR_OP_INC_RW || op == PVR_OP_INC_WR)) begin
      post_inc = 1'b1; // see RULE21
    end
    if (rd_data && op == PVR_OP_INC_RW) begin
      post_inc = 1'b1; // see RULE21
    end
    if (post_inc) begin
      eaddr_d = eaddr_q + 16'h0001;
    end
  end

  // Strobes carry the address from before any post-increment
  always_comb begin
    eaddr_hold_d = eaddr_q;
    edev_d = ectl_q[4:0]; // see RULE20
  end

  // Receive options
  always_comb begin
    exp_d = exp_q;
    if (wr_exp) begin
      exp_d = req.wdata; // see RULE1
    end
  end

  // Interrupt enables, event flags and pin level
  always_comb begin
    ien_d = ien_q;
    iflag_d = iflag_q | stat.events; // see RULE5
    if (wr_int) begin
      ien_d = req.wdata[15:8]; // see RULE4
    end
    // A read clears; an event in the read cycle survives
    if (rd_int) begin
      iflag_d = stat.events; // see RULE5
    end
    // Pin follows the next flags, so it deasserts with the read
    irq_d = ~(|(iflag_d & ien_d)); // see RULE6
    if (phy2_d[PVR_P2_INTLVL_BIT]) begin
      irq_d = |(iflag_d & ien_d); // see RULE7
    end
  end

  // Diagnostic enable clears itself when the core reports done
  always_comb begin
    cab_d = cab_q;
    if (cab_q[PVR_CAB_EN_BIT] && stat.cab_done) begin
      cab_d[PVR_CAB_EN_BIT] = 1'b0; // see RULE8
    end
    // Only the spare bits take written values; a written one sets the start bit
    if (wr_cab) begin
      cab_d = (cab_d & ~PVR_CAB_WMASK) | (req.wdata & PVR_CAB_WMASK);
      if (req.wdata[PVR_CAB_EN_BIT]) begin
        cab_d[PVR_CAB_EN_BIT] = 1'b1; // see RULE8
      end
    end
  end

  // First control register: only the isolate bit is writable
  always_comb begin
    phy1_d = phy1_q;
    if (wr_phy1) begin
      phy1_d = req.wdata & PVR_PHY1_WMASK; // see RULE11
    end
  end

  // Second control register: every bit writable
  always_comb begin
    phy2_d = phy2_q;
    if (wr_phy2) begin
      phy2_d = req.wdata; // see RULE13
    end
  end

  // Extended space strobes, only in a data operation
  always_comb begin
    ewr_d = wr_data && data_mode; // see RULE22
    erd_d = rd_data && data_mode; // see RULE22
    ewdata_d = ewdata_q;
    if (ewr_d) begin
      ewdata_d = req.wdata;
    end
  end

  // Pair roles: fixed when auto crossover off, else core decides
  always_comb begin
    if (phy2_d[PVR_P2_SWAPDIS_BIT]) begin
      pair_d = phy2_d[PVR_P2_MDIX_BIT]; // see RULE13
    end else begin
      pair_d = stat.mdix_state;
    end
  end

  // Indicator functions per mode field; spare codes act as zero
  always_comb begin
    if (phy2_d[PVR_P2_LED_LO +: 2] == 2'b01) begin
      second_indicator_output_d = activity; // see RULE18
      first_indicator_output_d = stat.link_up;
    end else begin
      second_indicator_output_d = speed_100; // see RULE18
      first_indicator_output_d = stat.link_up & ~activity;
    end
  end

  // Read data, decoded by address; unmapped reads as zero
  always_comb begin
    rdata_d = PVR_ZERO16;
    if (req.rd) begin
      if (req.addr == PVR_ADDR_EXT_CTRL) begin
        rdata_d = ectl_q;
      end else if (req.addr == PVR_ADDR_EXT_DATA) begin
        if (!data_mode) begin
          rdata_d = eaddr_q; // see RULE22
        end else begin
          rdata_d = ext_rdata; // see RULE22
        end
      end else if (req.addr == PVR_ADDR_EXP_RX) begin
        rdata_d = exp_q;
      end else if (req.addr == PVR_ADDR_INT) begin
        rdata_d = {ien_q, iflag_q}; // see RULE5
      end else if (req.addr == PVR_ADDR_CABLE) begin
        rdata_d = {cab_q[PVR_CAB_EN_BIT], stat.cab_result, stat.cab_short,
                   cab_q[11:9], stat.cab_dist}; // see RULE9
      end else if (req.addr == PVR_ADDR_PHY1) begin
        rdata_d = {6'h00, 1'b0, stat.link_up, stat.pol_rev, 1'b0,
                   stat.mdix_state, stat.energy, phy1_q[PVR_PHY1_ISO_BIT],
                   stat.op_mode}; // see RULE10, see RULE12
      end else if (req.addr == PVR_ADDR_PHY2) begin
        rdata_d = phy2_q;
      end
    end
  end

  // Portal registers and the address latched for the strobes
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ectl_q <= PVR_ZERO16;
      eaddr_q <= PVR_ZERO16;
      eaddr_hold_q <= PVR_ZERO16;
      edev_q <= 5'h00;
    end else begin
      ectl_q <= ectl_d;
      eaddr_q <= eaddr_d;
      eaddr_hold_q <= eaddr_hold_d;
      edev_q <= edev_d;
    end
  end

  // Receive options register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      exp_q <= PVR_EXP_RX_RST;
    end else begin
      exp_q <= exp_d;
    end
  end

  // Interrupt state; pin idles high under the low-active default
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ien_q <= 8'h00;
      iflag_q <= 8'h00;
      irq_q <= 1'b1;
    end else begin
      ien_q <= ien_d;
      iflag_q <= iflag_d;
      irq_q <= irq_d;
    end
  end

  // Diagnostic register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cab_q <= PVR_ZERO16;
    end else begin
      cab_q <= cab_d;
    end
  end

  // First control register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      phy1_q <= PVR_ZERO16;
    end else begin
      phy1_q <= phy1_d;
    end
  end

  // Second control register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      phy2_q <= PVR_PHY2_RST;
    end else begin
      phy2_q <= phy2_d;
    end
  end

  // Read data, standing one cycle after the request
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= PVR_ZERO16;
    end else begin
      rdata <= rdata_d;
    end
  end

  // Extended space strobes and write data
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ewr_q <= 1'b0;
      erd_q <= 1'b0;
      ewdata_q <= PVR_ZERO16;
    end else begin
      ewr_q <= ewr_d;
      erd_q <= erd_d;
      ewdata_q <= ewdata_d;
    end
  end

  // Pair role pin
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pair_q <= 1'b0;
    end else begin
      pair_q <= pair_d;
    end
  end

  // Indicator pins
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      first_indicator_output_q <= 1'b0;
      second_indicator_output_q <= 1'b0;
    end else begin
      first_indicator_output_q <= first_indicator_output_d;
      second_indicator_output_q <= second_indicator_output_d;
    end
  end

  // Pins straight from their flip-flops
  assign irq_pin = irq_q;
  assign ext_wr = ewr_q;
  assign ext_rd = erd_q;
  assign ext_dev = edev_q;
  assign ext_addr = eaddr_hold_q;
  assign ext_wdata = ewdata_q;
  assign transmit_pair_is_rx = pair_q;
  assign first_indicator_output = first_indicator_output_q;
  assign second_indicator_output = second_indicator_output_q;

  // Control fields as flip-flop outputs
  assign ctrl.rx_var_latency = exp_q[PVR_EXP_LATENCY_BIT]; // see RULE1, see RULE2
  assign ctrl.rx_preamble_restore = exp_q[PVR_EXP_PREAMBLE_BIT]; // see RULE3
  assign ctrl.cab_start = cab_q[PVR_CAB_EN_BIT]; // see RULE8
  assign ctrl.isolate = phy1_q[PVR_PHY1_ISO_BIT]; // see RULE11
  assign ctrl.xalg_std = phy2_q[PVR_P2_XALG_BIT]; // see RULE14
  assign ctrl.mdix_sel = phy2_q[PVR_P2_MDIX_BIT];
  assign ctrl.swap_dis = phy2_q[PVR_P2_SWAPDIS_BIT];
  assign ctrl.force_link = phy2_q[PVR_P2_FORCE_BIT]; // see RULE15
  assign ctrl.power_save = phy2_q[PVR_P2_PSAVE_BIT]; // see RULE16
  assign ctrl.jabber_en = phy2_q[PVR_P2_JABEN_BIT]; // see RULE16
  assign ctrl.refclk_50 = phy2_q[PVR_P2_REFCLK_BIT]; // see RULE17
  assign ctrl.led_mode = phy2_q[PVR_P2_LED_LO +: 2];
  assign ctrl.tx_dis = phy2_q[PVR_P2_TXDIS_BIT]; // see RULE19
  assign ctrl.remote_loop = phy2_q[PVR_P2_RLOOP_BIT]; // see RULE19
  assign ctrl.sqe_en = phy2_q[PVR_P2_SQE_BIT]; // see RULE19
  assign ctrl.scr_dis = phy2_q[PVR_P2_SCRDIS_BIT]; // see RULE19

endmodule

//--- hw/pvr_pkg.sv
// Package for the vendor management register bank of a 10/100 transceiver.
// Assumes a management register port of 5-bit address, 16-bit data.
package pvr_pkg;
  // Register addresses
  localparam logic [4:0] PVR_ADDR_EXT_CTRL = 5'h0d;
  localparam logic [4:0] PVR_ADDR_EXT_DATA = 5'h0e;
  localparam logic [4:0] PVR_ADDR_EXP_RX = 5'h18;
  localparam logic [4:0] PVR_ADDR_INT = 5'h1b;
  localparam logic [4:0] PVR_ADDR_CABLE = 5'h1d;
  localparam logic [4:0] PVR_ADDR_PHY1 = 5'h1e;
  localparam logic [4:0] PVR_ADDR_PHY2 = 5'h1f;
  // Reset values
  localparam logic [15:0] PVR_EXP_RX_RST = 16'h0801;
  localparam logic [15:0] PVR_PHY2_RST = 16'h8100;
  localparam logic [15:0] PVR_ZERO16 = 16'h0000;
  // Field positions
  localparam int PVR_EXP_LATENCY_BIT = 10;
  localparam int PVR_EXP_PREAMBLE_BIT = 6;
  localparam int PVR_CAB_EN_BIT = 15;
  localparam int PVR_PHY1_ISO_BIT = 3;
  localparam int PVR_P2_XALG_BIT = 15;
  localparam int PVR_P2_MDIX_BIT = 14;
  localparam int PVR_P2_SWAPDIS_BIT = 13;
  localparam int PVR_P2_FORCE_BIT = 11;
  localparam int PVR_P2_PSAVE_BIT = 10;
  localparam int PVR_P2_INTLVL_BIT = 9;
  localparam int PVR_P2_JABEN_BIT = 8;
  localparam int PVR_P2_REFCLK_BIT = 7;
  localparam int PVR_P2_LED_LO = 4;
  localparam int PVR_P2_TXDIS_BIT = 3;
  localparam int PVR_P2_RLOOP_BIT = 2;
  localparam int PVR_P2_SQE_BIT = 1;
  localparam int PVR_P2_SCRDIS_BIT = 0;
  // Writable masks (reserved RO bits stay zero)
  localparam logic [15:0] PVR_CAB_WMASK = 16'h0e00;
  localparam logic [15:0] PVR_PHY1_WMASK = 16'h0008;
  // Extended space operation codes
  typedef enum logic [1:0] {
    PVR_OP_ADDR = 2'h0,
    PVR_OP_DATA = 2'h1,
    PVR_OP_INC_RW = 2'h2,
    PVR_OP_INC_WR = 2'h3
  } pvr_op_t;
  // Management access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } pvr_req_t;
  // Status from the PHY core
  typedef struct packed {
    logic [7:0] events;
    logic link_up;
    logic pol_rev;
    logic mdix_state;
    logic energy;
    logic [2:0] op_mode;
    logic cab_done;
    logic [1:0] cab_result;
    logic cab_short;
    logic [8:0] cab_dist;
  } pvr_stat_t;
  // Controls to the PHY core
  typedef struct packed {
    logic rx_var_latency;
    logic rx_preamble_restore;
    logic cab_start;
    logic isolate;
    logic xalg_std;
    logic mdix_sel;
    logic swap_dis;
    logic force_link;
    logic power_save;
    logic jabber_en;
    logic refclk_50;
    logic [1:0] led_mode;
    logic tx_dis;
    logic remote_loop;
    logic sqe_en;
    logic scr_dis;
  } pvr_ctrl_t;
endpackage

//--- test/pvr_regs_checker.sv
// Checker for the register bank: controls, extended write strobe and diagnostic bit.
// Assumes it is bound to pvr_regs and sees its ports only.
module pvr_regs_checker
  import pvr_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire pvr_req_t req,
  input wire pvr_stat_t stat,
  input wire pvr_ctrl_t ctrl,
  input wire logic ext_wr,
  input wire logic transmit_pair_is_rx
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // A write strobe to one register
  sequence s_wr(a);
    req.wr && req.addr == a;
  endsequence
  // Controls follow the written bits one cycle later
  property p_iso; s_wr(PVR_ADDR_PHY1) |=>
    ctrl.isolate == $past(req.wdata[3]); endproperty
  a_iso: assert property (p_iso)
    else $error("isolate bit not taken");
  property p_phy2; s_wr(PVR_ADDR_PHY2) |=> ctrl.xalg_std ==
    $past(req.wdata[15]) && ctrl.led_mode == $past(req.wdata[5:4]);
  endproperty
  a_phy2: assert property (p_phy2)
    else $error("control two fields not taken");
  property p_exp; s_wr(PVR_ADDR_EXP_RX) |=> ctrl.rx_var_latency ==
    $past(req.wdata[10]) && ctrl.rx_preamble_restore ==
    $past(req.wdata[6]); endproperty
  a_exp: assert property (p_exp)
    else $error("receive options not taken");
  property p_hold; !req.wr |=>
    $stable(ctrl.led_mode) && $stable(ctrl.isolate); endproperty
  a_hold: assert property (p_hold)
    else $error("control changed without a write");
  property p_cab_set; req.wr && req.addr == PVR_ADDR_CABLE &&
    req.wdata[15] |=> ctrl.cab_start; endproperty
  a_cab_set: assert property (p_cab_set)
    else $error("diagnostic start not taken");
  property p_cab_clr; stat.cab_done |=> !ctrl.cab_start; endproperty
  a_cab_clr: assert property (p_cab_clr)
    else $error("diagnostic bit did not self-clear");
  property p_swap; ctrl.swap_dis |->
    transmit_pair_is_rx == ctrl.mdix_sel; endproperty
  a_swap: assert property (p_swap)
    else $error("pair role not fixed by select");
  property p_ext_wr; ext_wr |->
    $past(req.wr && req.addr == PVR_ADDR_EXT_DATA); endproperty
  a_ext_wr: assert property (p_ext_wr)
    else $error("extended write without portal write");
endmodule
bind pvr_regs pvr_regs_checker chk_u (.clock(clock), .arst_n(arst_n),
  .req(req), .stat(stat), .ctrl(ctrl), .ext_wr(ext_wr),
  .transmit_pair_is_rx(transmit_pair_is_rx));

//--- test/pvr_ext_model.sv
// Far-side model of the extended register space behind the portal.
// Assumes the bank's registered strobe, address and data outputs.
module pvr_ext_model
  import pvr_pkg::*;
(
  input wire logic clock,
  input wire logic ext_wr,
  input wire logic [15:0] ext_addr,
  input wire logic [15:0] ext_wdata,
  output logic [15:0] ext_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem_q [32];
  // Uniform content, so reads do not hinge on address timing
  initial foreach (mem_q[i]) mem_q[i] = 16'hc3a5;
  // Store data writes; one small space serves all devices
  always @(posedge clock) begin
    if (ext_wr) mem_q[ext_addr[4:0]] <= ext_wdata;
  end
  assign ext_rdata = mem_q[ext_addr[4:0]];
endmodule

//--- test/phy_vendor_regs_mmd_portal_test.sv
// Self-checking bench for the register bank and its portal.
// Assumes the extended space model on the far side.
module phy_vendor_regs_mmd_portal_test
  import pvr_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  pvr_req_t req = '0;
  pvr_stat_t stat = '0;
  logic speed_100 = 1'b0;
  logic activity = 1'b0;
  logic [15:0] rdata, ext_addr, ext_wdata, ext_rdata, d;
  pvr_ctrl_t ctrl;
  logic irq_pin, ext_wr, rd_q, pair;
  logic [2:0] modes [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [15:0] exp_q [$];
  always #25 clock = ~clock;
  pvr_regs dut_u (.clock(clock), .arst_n(arst_n), .req(req),
    .stat(stat), .rdata(rdata), .ctrl(ctrl), .irq_pin(irq_pin),
    .ext_wr(ext_wr), .ext_rd(), .ext_dev(), .ext_addr(ext_addr),
    .ext_wdata(ext_wdata), .ext_rdata(ext_rdata),
    .transmit_pair_is_rx(pair), .first_indicator_output(),
    .second_indicator_output(), .speed_100(speed_100),
    .activity(activity));
  pvr_ext_model model_u (.clock(clock), .ext_wr(ext_wr),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata));
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // One request for one cycle, placed at a falling edge
  task automatic op(logic w, logic r, logic [4:0] a, logic [15:0] v);
    req = '{w, r, a, v};
    @(negedge clock);
  endtask
  task automatic wr(logic [4:0] a, logic [15:0] v);
    op(1'b1, 1'b0, a, v);
  endtask
  task automatic rd(logic [4:0] a, logic [15:0] e);
    exp_q.push_back(e);
    op(1'b0, 1'b1, a, 16'h0000);
  endtask
  task automatic idle(int n);
    repeat (n) op(1'b0, 1'b0, 5'h00, 16'h0000);
  endtask
  task automatic pulse(logic [7:0] e);
    stat.events = e;
    idle(1);
    stat.events = 8'h00;
    idle(2);
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Watcher: read data lands one cycle after the request edge
  always @(posedge clock) rd_q <= req.rd;
  always @(negedge clock) begin
    if (rd_q === 1'b1 && exp_q.size() > 0)
      chk("rdata", exp_q.pop_front(), rdata);
  end
  // Random indicator inputs and the hang limit
  always @(negedge clock) {speed_100, activity} <= 2'($urandom);
  always @(posedge clock) begin
    cyc++;
    if (cyc == 4000) begin
      errors++;
      final_report();
    end
  end
  initial begin
    d = 16'($urandom(32'h8821));
    repeat (10) @(negedge clock);
    arst_n = 1'b1;
    rd(PVR_ADDR_EXP_RX, 16'h0801);
    rd(PVR_ADDR_PHY2, 16'h8100);
    rd(PVR_ADDR_INT, 16'h0000);
    rd(PVR_ADDR_EXT_CTRL, 16'h0000);
    rd(5'h05, 16'h0000);
    d = 16'($urandom);
    wr(PVR_ADDR_PHY2, d);
    rd(PVR_ADDR_PHY2, d);
    d = 16'($urandom);
    wr(PVR_ADDR_EXP_RX, d);
    rd(PVR_ADDR_EXP_RX, d);
    $display("test reset and read-write done");
    wr(PVR_ADDR_PHY2, 16'h6000);
    wr(PVR_ADDR_INT, 16'hff00 | (16'($urandom) & 16'h00ff));
    chk("pair", 16'h0001, 16'(pair));
    for (int i = 0; i < 8; i++) begin
      pulse(8'h01 << i);
      chk("irq", 16'h0000, 16'(irq_pin));
      rd(PVR_ADDR_INT, 16'hff00 | (16'h0001 << i));
      idle(2);
      chk("irq", 16'h0001, 16'(irq_pin));
    end
    wr(PVR_ADDR_PHY2, 16'h2200);
    wr(PVR_ADDR_INT, 16'h1000);
    chk("pair", 16'h0000, 16'(pair));
    pulse(8'h01);
    chk("irq", 16'h0000, 16'(irq_pin));
    pulse(8'h10);
    chk("irq", 16'h0001, 16'(irq_pin));
    rd(PVR_ADDR_INT, 16'h1011);
    $display("test interrupts done");
    for (int i = 0; i < 4; i++) begin
      stat.cab_result = i[1:0];
      stat.cab_short = i[0];
      stat.cab_dist = 9'($urandom);
      wr(PVR_ADDR_CABLE, 16'h8e00);
      rd(PVR_ADDR_CABLE, {1'b1, i[1:0], i[0], 3'h7, stat.cab_dist});
      stat.cab_done = 1'b1;
      idle(1);
      stat.cab_done = 1'b0;
      rd(PVR_ADDR_CABLE, {1'b0, i[1:0], i[0], 3'h7, stat.cab_dist});
    end
    $display("test cable diagnostic done");
    foreach (modes[i]) begin
      d = 16'($urandom);
      {stat.link_up, stat.pol_rev, stat.mdix_state, stat.energy} = d[7:4];
      stat.op_mode = modes[i];
      wr(PVR_ADDR_PHY1, d);
      rd(PVR_ADDR_PHY1, {7'h00, d[7:6], 1'b0, d[5:3], modes[i]});
    end
    $display("test status done");
    d = 16'($urandom);
    wr(PVR_ADDR_EXT_CTRL, 16'h0005);
    wr(PVR_ADDR_EXT_DATA, 16'h0005);
    wr(PVR_ADDR_EXT_CTRL, 16'h4005);
    wr(PVR_ADDR_EXT_DATA, d);
    idle(1);
    rd(PVR_ADDR_EXT_DATA, d);
    rd(PVR_ADDR_EXT_CTRL, 16'h4005);
    wr(PVR_ADDR_EXT_CTRL, 16'h0005);
    rd(PVR_ADDR_EXT_DATA, 16'h0005);
    wr(PVR_ADDR_EXT_CTRL, 16'h001f);
    wr(PVR_ADDR_EXT_DATA, 16'h0019);
    wr(PVR_ADDR_EXT_CTRL, 16'h801f);
    rd(PVR_ADDR_EXT_DATA, 16'hc3a5);
    rd(PVR_ADDR_EXT_DATA, 16'hc3a5);
    wr(PVR_ADDR_EXT_CTRL, 16'hc01f);
    rd(PVR_ADDR_EXT_DATA, 16'hc3a5);
    wr(PVR_ADDR_EXT_DATA, 16'hc3a5);
    wr(PVR_ADDR_EXT_CTRL, 16'h001f);
    rd(PVR_ADDR_EXT_DATA, 16'h001c);
    idle(3);
    $display("test portal done");
    final_report();
  end
endmodule
